// file: pmwc_pkg.sv
package pmwc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_WAKE_CFG = 8'h04;
    localparam logic [ADDR_W-1:0] REG_TIMER_LIMIT = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_RTC = 8'h10;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_SAVE_REQ = 0;
    localparam int CTRL_NVM_ON = 1;
    localparam int CTRL_DIV_LSB = 4;
    localparam int DIV_W = 4;
    localparam int WCFG_RF_EN = 0;
    localparam int WCFG_PIN_EN = 1;
    localparam int WCFG_PIN_POL = 2;
    localparam int WCFG_TMR_EN = 3;
    localparam int STAT_MODE = 0;
    localparam int STAT_PASSIVE = 1;
    localparam int STAT_SAVE_PEND = 2;
    localparam int STAT_SLEEP = 3;
    localparam int STAT_CAUSE_LSB = 4;
    localparam int CAUSE_W = 3;
    localparam int CAUSE_RF = 0;
    localparam int CAUSE_PIN = 1;
    localparam int CAUSE_TMR = 2;
    localparam int TIMER_W = 24;
    localparam int RTC_W = 32;
    localparam int WAKE_SRC_N = 20;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic RST_NVM_ON = 1'b1;
    localparam logic [DIV_W-1:0] RST_DIV = 4'h0;
    localparam logic [TIMER_W-1:0] RST_TIMER_LIMIT = 24'h008000;

    typedef enum {PM_POR, PM_DETECT, PM_CHARGE, PM_OSC_UP, PM_RUN, PM_SAVE_ENTER, PM_SAVE} pmwc_state_t;

    // Pins from outside the clock domain, synchronised as one vector
    typedef struct packed {
        logic supplyPresent;
        logic rfField;
        logic wakePin;
        logic capCharged;
        logic oscStable;
        logic coreGood;
        logic sleepReq;
        logic [WAKE_SRC_N-1:0] wakeSrc;
    } pmwc_pins_t;

    typedef struct packed {
        logic standbyOn;
        logic coreOn;
        logic ioOn;
        logic nvmOn;
        logic bridgeOn;
        logic rfOn;
        logic fastOscOn;
        logic slowOscOn;
    } pmwc_pwr_t;

    typedef struct packed {
        logic cpuClkEn;
        logic memClkEn;
        logic periphClkEn;
        logic rfPhyClkEn;
    } pmwc_clk_t;

endpackage : pmwc_pkg

// file: pmwc_power_model.sv
`timescale 1ns/10ps
module pmwc_power_model
    import pmwc_pkg::*;
(
    input wire logic clk,
    input wire pmwc_pwr_t pwrOut,
    input wire logic bridgeChargeEn,
    output logic oscStable,
    output logic coreGood,
    output logic capCharged
);
    int oscCnt = 0;
    int capCnt = 0;
    // Stability is lost at the next edge after power goes, so no stale ready level
    always @(posedge clk) begin
        oscCnt <= pwrOut.fastOscOn ? oscCnt + 1 : 0;
        capCnt <= bridgeChargeEn ? capCnt + 1 : 0;
    end
    assign oscStable = oscCnt > 6;
    assign coreGood = pwrOut.coreOn && oscCnt > 9;
    assign capCharged = capCnt > 12;
endmodule : pmwc_power_model

// file: pmwc_top.sv
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
// How it works
// - Two system modes, operating and power-save, with the active one tracked.
// - When external or field supply appears, start up into operating mode.
// - Software requests power-save; the sequencer accepts it and performs entry.
// - Power-save turns core, I/O, memory, bridge off; operating turns them on.
// - Memory domain is software controlled in operating mode, on after entry.
// - Fast oscillator off in power-save, on when operating; slow one always runs.
// - Field domain is powered only while a field is present, in both modes.
// - Software enables wake conditions first; an enabled one returns to operating.
// - Enabled field detection ends power-save.
// - Enabled wake pin at its software-selected level ends power-save.
// - Enabled standby timer counts ticks from power-save entry, wakes at limit.
// - The always-on slow clock runs all sequencing and the standby timer.
// - Fast clock serves CPU and core, divided by a firmware programmed ratio.
// - Carrier-derived clock drives the field physical layer logic while present.
// - In operating mode a wait instruction from the CPU enters sleep.
// - Any interrupt ends sleep and restores the CPU clock.
// - Sleep gates CPU and memory clocks; peripheral clocks keep running.
// - Sleep wake logic takes 20 sources: 18 interrupts, NMI, receive event.
// - At power on, detect external supply to pick active or passive operation.
// - Passive operation charges the bridge storage capacitor under control first.
// - Always-on logic holds standby timer and real-time counter, running in power-save.
module pmwc_top
    import pmwc_pkg::*;
#(
    parameter int TIMER_BITS = TIMER_W,
    parameter int RTC_BITS = RTC_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdata,
    input wire pmwc_pins_t pinsIn,
    output pmwc_pwr_t pwrOut,
    output pmwc_clk_t clkOut,
    output logic coreRst_n,
    output logic bridgeChargeEn,
    output logic [DIV_W-1:0] fastDivRatio,
    output logic operatingMode
);

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rstSync_q;
    logic rstInt_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync_q <= 2'b00;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstInt_n = rstSync_q[1];

    // ****************************************
    // Input synchroniser
    // ****************************************
    // A change is taken only when stage two and three agree, which also
    // rejects a single-cycle glitch on the wake pin or a supply detector.
    localparam int PIN_W = $bits(pmwc_pins_t);
    logic [PIN_W-1:0] syn1_q, syn2_q, syn3_q, filt_q, filt_d;
    pmwc_pins_t pins;

    assign filt_d = (syn2_q & syn3_q) | (filt_q & (syn2_q | syn3_q));

    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            syn1_q <= '0;
            syn2_q <= '0;
            syn3_q <= '0;
            filt_q <= '0;
        end else begin
            syn1_q <= pinsIn;
            syn2_q <= syn1_q;
            syn3_q <= syn2_q;
            filt_q <= filt_d;
        end
    end
    assign pins = pmwc_pins_t'(filt_q);

    // ****************************************
    // Register decode
    // ****************************************
    logic selCtrl, selWcfg, selLimit, selStat, selRtc;
    logic wrCtrl, wrWcfg, wrLimit, wrStat;
    assign selCtrl = (regAddr == REG_CTRL);
    assign selWcfg = (regAddr == REG_WAKE_CFG);
    assign selLimit = (regAddr == REG_TIMER_LIMIT);
    assign selStat = (regAddr == REG_STATUS);
    assign selRtc = (regAddr == REG_RTC);
    assign wrCtrl = regWr && selCtrl;
    assign wrWcfg = regWr && selWcfg;
    assign wrLimit = regWr && selLimit;
    assign wrStat = regWr && selStat;

    pmwc_state_t state_q, state_d;
    logic nvmOn_q, rfWakeEn_q, pinWakeEn_q, pinPol_q, tmrWakeEn_q;
    logic [DIV_W-1:0] div_q;
    logic [TIMER_BITS-1:0] limit_q;

    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            nvmOn_q <= RST_NVM_ON;
            div_q <= RST_DIV;
        end else if (wrCtrl) begin
            nvmOn_q <= regWdata[CTRL_NVM_ON];
            div_q <= regWdata[CTRL_DIV_LSB +: DIV_W];
        end else if (state_q == PM_SAVE) begin
            nvmOn_q <= RST_NVM_ON;
        end
    end

    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            rfWakeEn_q <= 1'b0;
            pinWakeEn_q <= 1'b0;
            pinPol_q <= 1'b0;
            tmrWakeEn_q <= 1'b0;
        end else if (wrWcfg) begin
            rfWakeEn_q <= regWdata[WCFG_RF_EN];
            pinWakeEn_q <= regWdata[WCFG_PIN_EN];
            pinPol_q <= regWdata[WCFG_PIN_POL];
            tmrWakeEn_q <= regWdata[WCFG_TMR_EN];
        end
    end

    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            limit_q <= TIMER_BITS'(RST_TIMER_LIMIT);
        end else if (wrLimit) begin
            limit_q <= regWdata[TIMER_BITS-1:0];
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    logic passive_q, saveReq_q, sleep_q;
    logic [TIMER_BITS-1:0] tmr_q;
    logic [RTC_BITS-1:0] rtc_q;
    logic [CAUSE_W-1:0] cause_q, causeSet;
    logic rfWake, pinWake, tmrWake, anyWake, supplyUp, railsStable;

    assign rfWake = rfWakeEn_q && pins.rfField;
    assign pinWake = pinWakeEn_q && (pins.wakePin == pinPol_q);
    assign tmrWake = tmrWakeEn_q && (tmr_q == limit_q);
    assign anyWake = rfWake || pinWake || tmrWake;
    assign supplyUp = pins.supplyPresent || pins.rfField;
    assign railsStable = pins.oscStable && pins.coreGood;
    assign causeSet = {tmrWake, pinWake, rfWake} & {CAUSE_W{state_q == PM_SAVE}};

    always_comb begin
        state_d = state_q;
        case (state_q)
            PM_POR: begin
                if (supplyUp) begin
                    state_d = PM_DETECT;
                end
            end
            PM_DETECT: begin
                state_d = pins.supplyPresent ? PM_OSC_UP : PM_CHARGE;
            end
            PM_CHARGE: begin
                if (pins.capCharged) begin
                    state_d = PM_OSC_UP;
                end
            end
            PM_OSC_UP: begin
                if (railsStable) begin
                    state_d = PM_RUN;
                end
            end
            PM_RUN: begin
                if (saveReq_q) begin
                    state_d = PM_SAVE_ENTER;
                end
            end
            PM_SAVE_ENTER: begin
                state_d = PM_SAVE;
            end
            PM_SAVE: begin
                if (anyWake) begin
                    state_d = PM_OSC_UP;
                end
            end
            default: begin
                state_d = PM_POR;
            end
        endcase
    end

    // Sequencing runs on the always-on slow clock, so it keeps going in power-save
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            state_q <= PM_POR;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            passive_q <= 1'b0;
        end else if (state_q == PM_DETECT) begin
            passive_q <= !pins.supplyPresent;
        end
    end

    // Request is held until the sequencer takes it; a new write while
    // leaving operating mode cannot be lost because set wins.
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            saveReq_q <= 1'b0;
        end else if (wrCtrl && regWdata[CTRL_SAVE_REQ]) begin
            saveReq_q <= 1'b1;
        end else if (state_q == PM_SAVE_ENTER) begin
            saveReq_q <= 1'b0;
        end
    end

    // Counting starts from zero on entry, and holds at the limit
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            tmr_q <= '0;
        end else if (state_q != PM_SAVE) begin
            tmr_q <= '0;
        end else if (tmrWakeEn_q && tmr_q != limit_q) begin
            tmr_q <= tmr_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            rtc_q <= '0;
        end else begin
            rtc_q <= rtc_q + 1'b1;
        end
    end

    // Wake cause is sticky and cleared by writing one; a new cause wins
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            cause_q <= '0;
        end else if (wrStat) begin
            cause_q <= (cause_q & ~regWdata[STAT_CAUSE_LSB +: CAUSE_W]) | causeSet;
        end else begin
            cause_q <= cause_q | causeSet;
        end
    end

    // ****************************************
    // CPU sleep
    // ****************************************
    logic anyIrq;
    assign anyIrq = |pins.wakeSrc;

    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            sleep_q <= 1'b0;
        end else if (state_q != PM_RUN || anyIrq) begin
            sleep_q <= 1'b0;
        end else if (pins.sleepReq) begin
            sleep_q <= 1'b1;
        end
    end

    // ****************************************
    // Power and clock outputs
    // ****************************************
    logic coreUp, running;
    pmwc_pwr_t pwr_d;
    pmwc_clk_t clk_d;
    assign coreUp = (state_q == PM_OSC_UP) || (state_q == PM_RUN) || (state_q == PM_SAVE_ENTER);
    assign running = (state_q == PM_RUN);

    always_comb begin
        pwr_d.standbyOn = 1'b1;
        pwr_d.coreOn = coreUp;
        pwr_d.ioOn = coreUp;
        pwr_d.nvmOn = coreUp && nvmOn_q;
        pwr_d.bridgeOn = coreUp;
        pwr_d.rfOn = pins.rfField;
        pwr_d.fastOscOn = coreUp;
        pwr_d.slowOscOn = 1'b1;
        clk_d.cpuClkEn = running && !sleep_q;
        clk_d.memClkEn = running && !sleep_q;
        clk_d.periphClkEn = running;
        clk_d.rfPhyClkEn = pins.rfField;
    end

    // Outputs are registered so domain switches never glitch
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            pwrOut <= '0;
            clkOut <= '0;
            coreRst_n <= 1'b0;
            bridgeChargeEn <= 1'b0;
            fastDivRatio <= RST_DIV;
            operatingMode <= 1'b0;
        end else begin
            pwrOut <= pwr_d;
            clkOut <= clk_d;
            coreRst_n <= running;
            bridgeChargeEn <= (state_q == PM_CHARGE) && passive_q;
            fastDivRatio <= div_q;
            operatingMode <= running;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Each field lands at its named position; the save request reads back as zero
    logic [DATA_W-1:0] rdMux, ctrlRd, wcfgRd, statRd;
    assign ctrlRd = (DATA_W'(div_q) << CTRL_DIV_LSB) | (DATA_W'(nvmOn_q) << CTRL_NVM_ON);
    assign wcfgRd = (DATA_W'(tmrWakeEn_q) << WCFG_TMR_EN) | (DATA_W'(pinPol_q) << WCFG_PIN_POL) |
                    (DATA_W'(pinWakeEn_q) << WCFG_PIN_EN) | (DATA_W'(rfWakeEn_q) << WCFG_RF_EN);
    assign statRd = (DATA_W'(cause_q) << STAT_CAUSE_LSB) | (DATA_W'(sleep_q) << STAT_SLEEP) |
                    (DATA_W'(saveReq_q) << STAT_SAVE_PEND) | (DATA_W'(passive_q) << STAT_PASSIVE) |
                    (DATA_W'(running) << STAT_MODE);
    assign rdMux = selCtrl ? ctrlRd :
                   selWcfg ? wcfgRd :
                   selLimit ? DATA_W'(limit_q) :
                   selStat ? statRd :
                   selRtc ? DATA_W'(rtc_q) : '0;

    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            regRdata <= '0;
        end else begin
            regRdata <= regRd ? rdMux : '0;
        end
    end

endmodule : pmwc_top

// file: pmwc_top_assertions.sv
`timescale 1ns/10ps
module pmwc_top_checker
    import pmwc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [DATA_W-1:0] regRdata,
    input wire pmwc_pins_t pinsIn,
    input wire pmwc_pwr_t pwrOut,
    input wire pmwc_clk_t clkOut,
    input wire logic coreRst_n,
    input wire logic bridgeChargeEn,
    input wire logic [DIV_W-1:0] fastDivRatio,
    input wire logic operatingMode
);
    logic [3:0] upCnt_q;
    logic [DIV_W-1:0] divExp_q;
    // Outputs stay low for the first edges after release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upCnt_q <= 4'h0;
            divExp_q <= 4'h0;
        end else begin
            if (upCnt_q != 4'hF) upCnt_q <= upCnt_q + 4'h1;
            if (regWr && regAddr == REG_CTRL) divExp_q <= regWdata[CTRL_DIV_LSB +: DIV_W];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_run_power;
        operatingMode |-> pwrOut.coreOn && pwrOut.ioOn && pwrOut.bridgeOn && pwrOut.standbyOn;
    endproperty
    a_run_power: assert property (p_run_power) else $error("domain off in operating mode");
    property p_rst_order;
        coreRst_n |-> $past(pwrOut.coreOn) && $past(pwrOut.fastOscOn) && operatingMode;
    endproperty
    a_rst_order: assert property (p_rst_order) else $error("core reset released too early");
    property p_osc_core;
        pwrOut.fastOscOn == pwrOut.coreOn;
    endproperty
    a_osc_core: assert property (p_osc_core) else $error("fast oscillator out of step");
    property p_always_on;
        upCnt_q >= 4'h4 |-> pwrOut.standbyOn && pwrOut.slowOscOn;
    endproperty
    a_always_on: assert property (p_always_on) else $error("standby domain off");
    property p_save_off;
        $fell(operatingMode) |-> ##[1:3] !(pwrOut.coreOn || pwrOut.ioOn || pwrOut.nvmOn || pwrOut.bridgeOn);
    endproperty
    a_save_off: assert property (p_save_off) else $error("domains on in power-save");
    property p_nvm_entry;
        $rose(operatingMode) |-> pwrOut.nvmOn;
    endproperty
    a_nvm_entry: assert property (p_nvm_entry) else $error("memory domain off at entry");
    property p_rf_off;
        (!pinsIn.rfField) [*8] |-> !pwrOut.rfOn && !clkOut.rfPhyClkEn;
    endproperty
    a_rf_off: assert property (p_rf_off) else $error("field domain on without field");
    property p_sleep_gate;
        operatingMode && !clkOut.cpuClkEn |-> !clkOut.memClkEn && clkOut.periphClkEn;
    endproperty
    a_sleep_gate: assert property (p_sleep_gate) else $error("sleep gating wrong");
    property p_wake_sleep;
        (operatingMode && |pinsIn.wakeSrc) [*8] |-> clkOut.cpuClkEn;
    endproperty
    a_wake_sleep: assert property (p_wake_sleep) else $error("sleep not left on wake source");
    property p_div;
        regWr && regAddr == REG_CTRL |-> ##2 fastDivRatio == divExp_q;
    endproperty
    a_div: assert property (p_div) else $error("divider ratio not taken");
    property p_charge;
        bridgeChargeEn |-> !operatingMode && !coreRst_n;
    endproperty
    a_charge: assert property (p_charge) else $error("charging outside start-up");
    property p_status_mode;
        regRd && regAddr == REG_STATUS && operatingMode && $past(operatingMode) |=> regRdata[STAT_MODE];
    endproperty
    a_status_mode: assert property (p_status_mode) else $error("mode bit wrong");
    c_save: cover property ($fell(operatingMode));
    c_wake: cover property ($rose(operatingMode));
    c_sleep: cover property ($fell(clkOut.cpuClkEn));
endmodule : pmwc_top_checker

bind pmwc_top pmwc_top_checker i_chk (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pinsIn(pinsIn), .pwrOut(pwrOut), .clkOut(clkOut),
    .coreRst_n(coreRst_n), .bridgeChargeEn(bridgeChargeEn), .fastDivRatio(fastDivRatio),
    .operatingMode(operatingMode));

// file: tb.sv
`timescale 1ns/10ps
module tb;
    import pmwc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] regAddr = 8'h00;
    logic [DATA_W-1:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic supply = 1'b1;
    logic rf = 1'b0;
    logic wpin = 1'b1;
    logic slp = 1'b0;
    logic [WAKE_SRC_N-1:0] wakeSrc = 20'h0;
    logic capOk, oscOk, coreOk, coreRst_n, bridgeChargeEn, operatingMode;
    logic [DIV_W-1:0] fastDivRatio;
    logic [DATA_W-1:0] regRdata, rdv;
    pmwc_pins_t pins;
    pmwc_pwr_t pwr;
    pmwc_clk_t ck;
    int numErrors = 0;
    int totalChecks = 0;
    int c;
    logic [3:0] cfgs [4] = '{4'h1, 4'h2, 4'h6, 4'h8};
    int lo [4] = '{30, 30, 30, 94};
    int hi [4] = '{70, 70, 70, 160};
    int cause [4] = '{CAUSE_RF, CAUSE_PIN, CAUSE_PIN, CAUSE_TMR};
    assign pins = {supply, rf, wpin, capOk, oscOk, coreOk, slp, wakeSrc};
    initial begin
        forever #10 clk = ~clk;
    end
    pmwc_top i_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .pinsIn(pins), .pwrOut(pwr), .clkOut(ck), .coreRst_n(coreRst_n),
        .bridgeChargeEn(bridgeChargeEn), .fastDivRatio(fastDivRatio), .operatingMode(operatingMode));
    pmwc_power_model i_model (.clk(clk), .pwrOut(pwr), .bridgeChargeEn(bridgeChargeEn), .oscStable(oscOk),
        .coreGood(coreOk), .capCharged(capOk));
    task automatic finalReport();
        $display("checks %0d, mismatches %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finalReport
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        rdv = regRdata;
    endtask : rd
    // Bounded wait; a level that never comes ends the run
    task automatic waitfor(input int sel, input logic want, input int n, output int i);
        for (i = 0; i < n; i++) begin
            cyc(1);
            if ((sel == 0 ? operatingMode : sel == 1 ? ck.cpuClkEn : bridgeChargeEn) === want) break;
        end
        if (i == n) begin
            chk("wait bound", 32'h0, 32'h1);
            finalReport();
        end
    endtask : waitfor
    task automatic do_reset(input logic sup, input logic fld);
        rst_n <= 1'b0;
        supply <= sup;
        rf <= fld;
        cyc(20);
        rst_n <= 1'b1;
        cyc(3);
    endtask : do_reset
    initial begin
        do_reset(1'h1, 1'h0);
        waitfor(0, 1'h1, 200, c);
        chk("power run", {24'h0, pwr}, 32'hFB);
        chk("core reset", {31'h0, coreRst_n}, 32'h1);
        rd(REG_CTRL);
        chk("ctrl", rdv, 32'h2);
        rd(REG_WAKE_CFG);
        chk("wake cfg", rdv, 32'h0);
        rd(REG_TIMER_LIMIT);
        chk("limit", rdv, 32'h8000);
        rd(REG_STATUS);
        chk("status", {30'h0, rdv[1:0]}, 32'h1);
        rd(8'h14);
        chk("unmapped", rdv, 32'h0);
        rd(REG_RTC);
        c = rdv;
        rd(REG_RTC);
        chk("rtc step", rdv - c, 32'h2);
        wr(REG_TIMER_LIMIT, 32'h60);
        rd(REG_TIMER_LIMIT);
        chk("limit", rdv, 32'h60);
        wr(REG_CTRL, 32'h50);
        cyc(3);
        chk("nvm off", {31'h0, pwr.nvmOn}, 32'h0);
        chk("divider", {28'h0, fastDivRatio}, 32'h5);
        // Each wake source in turn ends a sleep
        for (int k = 0; k < WAKE_SRC_N; k++) begin
            slp <= 1'b1;
            waitfor(1, 1'h0, 20, c);
            chk("sleep clocks", {29'h0, ck[2:0]}, 32'h2);
            slp <= 1'b0;
            wakeSrc <= 20'h1 << k;
            waitfor(1, 1'h1, 20, c);
            // Held on so the wake source stands long enough for the sleep-exit check
            cyc(3);
            wakeSrc <= 20'h0;
            cyc(8);
        end
        // Trigger raises the field and flips the pin; only the enabled source may wake
        for (int k = 0; k < 4; k++) begin
            wpin <= ~cfgs[k][2];
            wr(REG_STATUS, 32'h70);
            wr(REG_WAKE_CFG, {28'h0, cfgs[k]});
            wr(REG_CTRL, 32'h1);
            waitfor(0, 1'h0, 20, c);
            cyc(10);
            chk("power save", {24'h0, pwr}, 32'h81);
            cyc(20);
            rf <= 1'b1;
            wpin <= cfgs[k][2];
            waitfor(0, 1'h1, 200, c);
            chk("wake time", {31'h0, c + 30 >= lo[k] && c + 30 <= hi[k]}, 32'h1);
            chk("nvm on", {31'h0, pwr.nvmOn}, 32'h1);
            chk("field clock", {30'h0, pwr.rfOn, ck.rfPhyClkEn}, 32'h3);
            rd(REG_STATUS);
            chk("cause", {29'h0, rdv[6:4]}, 32'h1 << cause[k]);
            rf <= 1'b0;
            cyc(10);
        end
        do_reset(1'h0, 1'h1);
        waitfor(2, 1'h1, 50, c);
        waitfor(0, 1'h1, 200, c);
        rd(REG_STATUS);
        chk("passive", {31'h0, rdv[STAT_PASSIVE]}, 32'h1);
        finalReport();
    end
endmodule : tb
